// >>> hdl/mrsc_pkg.sv
// package: register map, reset values and types for the run/stop controller
package mrsc_pkg;
    // register byte offsets
    localparam logic [5:0] MRSC_CTRL_OFS   = 6'h00;
    localparam logic [5:0] MRSC_SP1_OFS    = 6'h04;
    localparam logic [5:0] MRSC_SP2_OFS    = 6'h08;
    localparam logic [5:0] MRSC_SP3_OFS    = 6'h0C;
    localparam logic [5:0] MRSC_SP4_OFS    = 6'h10;
    localparam logic [5:0] MRSC_JOG_OFS    = 6'h14;
    localparam logic [5:0] MRSC_DECEL_OFS  = 6'h18;
    localparam logic [5:0] MRSC_LOALM_OFS  = 6'h1C;
    localparam logic [5:0] MRSC_HIALM_OFS  = 6'h20;
    localparam logic [5:0] MRSC_RERR_OFS   = 6'h24;
    localparam logic [5:0] MRSC_SERR_OFS   = 6'h28;
    localparam logic [5:0] MRSC_CONT_OFS   = 6'h2C;
    localparam logic [5:0] MRSC_PEAK_OFS   = 6'h30;
    localparam logic [5:0] MRSC_STAT_OFS   = 6'h34;
    localparam logic [5:0] MRSC_CURMON_OFS = 6'h38;
    localparam logic [5:0] MRSC_LIMMON_OFS = 6'h3C;
    // control register fields
    localparam int MRSC_CTRL_RUN_BIT   = 0; // write 1: remote run
    localparam int MRSC_CTRL_RSTOP_BIT = 1; // write 1: remote ramped stop
    localparam int MRSC_CTRL_FSTOP_BIT = 2; // write 1: remote fast stop
    localparam int MRSC_CTRL_ENLOG_BIT = 3; // enable_output_logic_setting
    localparam int MRSC_CTRL_AFMT_LSB  = 4; // alarm_format_setting, 4 bits
    // current settings in 0.1 A units
    localparam logic [15:0] MRSC_CONT_MIN = 16'h0028; // 4.0 A
    localparam logic [15:0] MRSC_CONT_MAX = 16'h0064; // 10.0 A
    localparam logic [15:0] MRSC_PEAK_MIN = 16'h0028; // 4.0 A
    localparam logic [15:0] MRSC_PEAK_MAX = 16'h0096; // 15.0 A
    localparam logic [15:0] MRSC_FULL_SPD = 16'hFFFF;
    // timing
    localparam int MRSC_CLK_MHZ    = 200;
    localparam int MRSC_TICK_US    = 1000; // ramp and duty tick, 1 ms
    localparam int MRSC_TICK_CYC   = MRSC_TICK_US * MRSC_CLK_MHZ;
    localparam int MRSC_WINDOW_MS  = 600000; // ten minutes
    localparam int MRSC_ALLOW_MS   = 60000;  // one minute
    localparam int MRSC_FBLOSS_MS  = 100;    // no feedback edge for this long
    // drive states
    typedef enum logic [2:0] {
        MRSC_IDLE, MRSC_RUN, MRSC_JOG, MRSC_RSTOP, MRSC_FSTOP
    } mrsc_state_t;
    // operator contacts, 1 = closed to common
    typedef struct packed {
        logic run;
        logic jog;
        logic rstop;
        logic fstop;
        logic follower;
        logic sp_sel;
    } mrsc_contacts_t;
    // measured quantities from the control loop
    typedef struct packed {
        logic [15:0] speed;      // scaled feedback
        logic [15:0] ramped_err; // magnitude
        logic [15:0] scaled_err; // magnitude
        logic [15:0] current;    // rms armature current, 0.1 A
    } mrsc_meas_t;
endpackage : mrsc_pkg

// >>> hdl/mrsc_ctrl.sv
// motor run/stop sequencing, setpoint selection, outputs and current limit
// Notes on behaviour
// RQ1 - momentary run closure latches running state
// RQ2 - run needs both stop inputs closed
// RQ3 - jog runs at jog speed while held
// RQ4 - jog only with stops closed, run open
// RQ5 - ramped stop latches, decelerates at set rate
// RQ6 - fast stop latches, zero speed at once
// RQ7 - master/follower input picks scaling
// RQ8 - setpoint one to four from two inputs
// RQ9 - lost feedback commands full output
// RQ10 - enable low while commanding nonzero speed; held high through a ramped stop
// RQ11 - enable high after power-up and stops
// RQ12 - alarm per format against four thresholds
// RQ13 - over-limit one minute per ten minutes
// RQ14 - peak current kept below peak limit
// RQ15 - continuous limit accepts 4.0 to 10.0 A
// RQ16 - peak limit accepts 4.0 to 15.0 A
// RQ17 - limit status monitor reads 0 or 1
// RQ18 - current monitor reports rms current in 0.1 A
// RQ19 - host writes settings, reads status, runs
// RQ20 - fast stop, ramped stop, run, jog priority; a host stop while idle is dropped, so a run in the same cycle wins
`timescale 1ns/1ps
module mrsc_ctrl
    import mrsc_pkg::*;
#(
    parameter int TICK_CYC  = MRSC_TICK_CYC,
    parameter int WINDOW_MS = MRSC_WINDOW_MS,
    parameter int ALLOW_MS  = MRSC_ALLOW_MS,
    parameter int FBLOSS_MS = MRSC_FBLOSS_MS
) (
    // clock and reset
    input  wire logic           clock,
    input  wire logic           rst_n,
    // avalon-mm slave
    input  wire logic [5:0]     address,
    input  wire logic           read,
    input  wire logic           write,
    input  wire logic [31:0]    writedata,
    output logic      [31:0]    readdata,
    output logic                waitrequest,
    // operator contacts and loop measurements
    input  wire mrsc_contacts_t contacts,
    input  wire mrsc_meas_t     meas,
    input  wire logic           fb_pulse,
    // drive side
    output logic      [15:0]    speed_cmd,
    output logic                follower_mode,
    output logic      [15:0]    current_clamp,
    output logic                drive_enable_n,
    output logic                alarm_n
);
    // sequencing state
    mrsc_state_t state_r;
    mrsc_state_t state_nxt;
    logic [15:0] spd_r;
    logic [15:0] spd_nxt;
    logic        stop_lat_r;
    logic        stop_lat_nxt;
    // bus side
    logic        wait_r;
    logic [31:0] rdata_r;
    // host settings
    logic        enlog_r;      // enable logic
    logic [3:0]  afmt_r;       // alarm format
    logic [15:0] sp_r [4];     // setpoints one to four
    logic [15:0] jog_r;
    logic [15:0] decel_r;      // drop per tick
    logic [15:0] loalm_r;
    logic [15:0] hialm_r;
    logic [15:0] rerr_r;
    logic [15:0] serr_r;
    logic [15:0] cont_r;
    logic [15:0] peak_r;
    // timers
    logic [31:0] tick_cnt_r;   // cycles in a tick
    logic [31:0] win_cnt_r;    // ticks into window
    logic [31:0] over_cnt_r;   // ticks over limit
    logic [31:0] fb_cnt_r;     // ticks since edge
    // supervision and outputs
    logic        fb_prev_r;
    logic        fb_lost_r;
    logic        clamp_cont_r;
    logic        limiting_r;
    logic [15:0] clamp_r;
    logic        den_n_r;
    logic        alarm_n_r;
    logic        follower_r;

    // bus decode
    // a write lands only while waitrequest is low,
    // so the wait state never applies it twice
    wire         wr_now   = write && !wait_r;
    wire [5:0]   ofs      = {address[5:2], 2'b00};
    wire [15:0]  wd16     = writedata[15:0];
    wire         rem_run  = wr_now && ofs == MRSC_CTRL_OFS
                            && writedata[MRSC_CTRL_RUN_BIT];
    wire         rem_rst  = wr_now && ofs == MRSC_CTRL_OFS
                            && writedata[MRSC_CTRL_RSTOP_BIT];
    wire         rem_fst  = wr_now && ofs == MRSC_CTRL_OFS
                            && writedata[MRSC_CTRL_FSTOP_BIT];
    wire         tick     = tick_cnt_r == 32'(TICK_CYC - 1);

    // setting range enforcement
    wire [15:0]  cont_wr  = wd16 < MRSC_CONT_MIN ? MRSC_CONT_MIN :
                            wd16 > MRSC_CONT_MAX ? MRSC_CONT_MAX : wd16; // RQ15
    wire [15:0]  peak_wr  = wd16 < MRSC_PEAK_MIN ? MRSC_PEAK_MIN :
                            wd16 > MRSC_PEAK_MAX ? MRSC_PEAK_MAX : wd16; // RQ16

    // contact conditions
    wire         stops_ok = contacts.rstop && contacts.fstop; // RQ2
    wire         fst_req  = !contacts.fstop || rem_fst;
    wire         rst_req  = !contacts.rstop || rem_rst;
    wire         run_req  = contacts.run || rem_run;
    wire         jog_ok   = stops_ok && !contacts.run && contacts.jog; // RQ4

    // setpoint select: index {follower, select}
    wire [1:0]   sp_idx   = {contacts.follower, contacts.sp_sel}; // RQ8
    wire [15:0]  sp_act   = sp_r[sp_idx];
    wire [15:0]  run_spd  = fb_lost_r ? MRSC_FULL_SPD : sp_act; // RQ9
    wire [15:0]  jog_spd  = fb_lost_r ? MRSC_FULL_SPD : jog_r; // RQ9
    wire [15:0]  ramp_dn  = spd_r > decel_r ? spd_r - decel_r : 16'h0000;

    // state and speed sequencing
    // stops are tested ahead of the case: fast stop beats any mode other than idle, ramped stop only run and jog;
    // a contact stop seen while idle only sets the latch
    always_comb begin
        state_nxt    = state_r;
        spd_nxt      = spd_r;
        stop_lat_nxt = stop_lat_r;
        if (fst_req && state_r != MRSC_IDLE) begin
            state_nxt    = MRSC_FSTOP; // RQ20
            stop_lat_nxt = 1'b1; // RQ6
            spd_nxt      = 16'h0000; // RQ6
        end else if (rst_req && (state_r == MRSC_RUN || state_r == MRSC_JOG)) begin
            state_nxt    = MRSC_RSTOP; // RQ20
            stop_lat_nxt = 1'b1; // RQ5
        end else begin
            case (state_r)
                MRSC_IDLE: begin
                    if (!stops_ok) begin
                        stop_lat_nxt = 1'b1;
                    end else if (jog_ok && !rem_run) begin
                        state_nxt = MRSC_JOG; // RQ4
                        spd_nxt   = jog_spd;
                    end else if (run_req) begin
                        state_nxt    = MRSC_RUN; // RQ1
                        stop_lat_nxt = 1'b0;
                        spd_nxt      = run_spd;
                    end
                end
                MRSC_RUN: begin
                    spd_nxt = run_spd; // RQ1
                end
                MRSC_JOG: begin
                    if (!contacts.jog || contacts.run) begin
                        state_nxt = MRSC_IDLE; // RQ3
                        spd_nxt   = 16'h0000;
                    end else begin
                        spd_nxt = jog_spd; // RQ3
                    end
                end
                MRSC_RSTOP: begin
                    if (spd_r == 16'h0000) begin
                        state_nxt = MRSC_IDLE;
                    end else if (tick) begin
                        spd_nxt = ramp_dn; // RQ5
                    end
                end
                MRSC_FSTOP: begin
                    spd_nxt   = 16'h0000;
                    state_nxt = MRSC_IDLE;
                end
                default: begin
                    state_nxt = MRSC_IDLE;
                    spd_nxt   = 16'h0000;
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= MRSC_IDLE;
            spd_r      <= 16'h0000;
            stop_lat_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            spd_r      <= spd_nxt;
            stop_lat_r <= stop_lat_nxt;
        end
    end

    // millisecond tick
    // paces the ramp, the overload budget and the watchdog
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        end
    end

    // feedback loss watchdog: no rising edge for the timeout
    // hazard: a lost sensor forces full output; the flag is
    // in status so the host can tell a runaway from a command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fb_prev_r <= 1'b0;
            fb_cnt_r  <= 32'h0000_0000;
            fb_lost_r <= 1'b0;
        end else begin
            fb_prev_r <= fb_pulse;
            if (fb_pulse && !fb_prev_r) begin
                fb_cnt_r  <= 32'h0000_0000;
                fb_lost_r <= 1'b0;
            end else if (tick && fb_cnt_r < 32'(FBLOSS_MS)) begin
                fb_cnt_r <= fb_cnt_r + 32'h0000_0001;
            end else if (fb_cnt_r >= 32'(FBLOSS_MS)) begin
                fb_lost_r <= 1'b1; // RQ9
            end
        end
    end

    // over-limit budget inside the fixed ten-minute window
    // the window free-runs from reset, not from the first overload;
    // once the budget is spent the clamp holds to the window end
    wire over_cont = meas.current > cont_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_r    <= 32'h0000_0000;
            over_cnt_r   <= 32'h0000_0000;
            clamp_cont_r <= 1'b0;
        end else if (tick) begin
            if (win_cnt_r == 32'(WINDOW_MS - 1)) begin
                win_cnt_r    <= 32'h0000_0000;
                over_cnt_r   <= 32'h0000_0000;
                clamp_cont_r <= 1'b0; // RQ13
            end else begin
                win_cnt_r <= win_cnt_r + 32'h0000_0001;
                if (over_cont && !clamp_cont_r) begin
                    over_cnt_r <= over_cnt_r + 32'h0000_0001;
                end
                if (over_cnt_r >= 32'(ALLOW_MS)) begin
                    clamp_cont_r <= 1'b1; // RQ13
                end
            end
        end
    end

    // current clamp and limiting status
    // the peak setting is never reached, so one step below is used;
    // status compares against the clamp about to apply
    wire [15:0] peak_lim  = peak_r - 16'h0001; // RQ14
    wire [15:0] clamp_nxt = clamp_cont_r ? cont_r : peak_lim; // RQ13
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clamp_r    <= 16'h0000;
            limiting_r <= 1'b0;
        end else begin
            clamp_r    <= clamp_nxt;
            limiting_r <= meas.current >= clamp_nxt; // RQ17
        end
    end

    // drive enable, alarm and mode outputs
    wire running  = state_r == MRSC_RUN || state_r == MRSC_JOG;
    wire en_cond  = enlog_r ? running : running && spd_r != 16'h0000; // RQ10
    wire alm_lo   = afmt_r[0] && meas.speed < loalm_r;
    wire alm_hi   = afmt_r[1] && meas.speed > hialm_r;
    wire alm_re   = afmt_r[2] && meas.ramped_err > rerr_r;
    wire alm_se   = afmt_r[3] && meas.scaled_err > serr_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            den_n_r    <= 1'b1; // RQ11
            alarm_n_r  <= 1'b1;
            follower_r <= 1'b0;
        end else begin
            den_n_r    <= !en_cond; // RQ11
            alarm_n_r  <= !(alm_lo || alm_hi || alm_re || alm_se); // RQ12
            follower_r <= contacts.follower; // RQ7
        end
    end

    // read mux
    // unmapped offsets read as zero
    logic [31:0] rmux;
    always_comb begin
        case (ofs)
            MRSC_CTRL_OFS:   rmux = {24'h00_0000, afmt_r, enlog_r, 3'b000};
            MRSC_SP1_OFS:    rmux = {16'h0000, sp_r[0]};
            MRSC_SP2_OFS:    rmux = {16'h0000, sp_r[1]};
            MRSC_SP3_OFS:    rmux = {16'h0000, sp_r[2]};
            MRSC_SP4_OFS:    rmux = {16'h0000, sp_r[3]};
            MRSC_JOG_OFS:    rmux = {16'h0000, jog_r};
            MRSC_DECEL_OFS:  rmux = {16'h0000, decel_r};
            MRSC_LOALM_OFS:  rmux = {16'h0000, loalm_r};
            MRSC_HIALM_OFS:  rmux = {16'h0000, hialm_r};
            MRSC_RERR_OFS:   rmux = {16'h0000, rerr_r};
            MRSC_SERR_OFS:   rmux = {16'h0000, serr_r};
            MRSC_CONT_OFS:   rmux = {16'h0000, cont_r};
            MRSC_PEAK_OFS:   rmux = {16'h0000, peak_r};
            MRSC_STAT_OFS:   rmux = {spd_r, 7'h00, fb_lost_r, !alarm_n_r,
                                     stop_lat_r, clamp_cont_r, 2'b00, state_r}; // RQ19
            MRSC_CURMON_OFS: rmux = {16'h0000, meas.current}; // RQ18
            MRSC_LIMMON_OFS: rmux = {31'h0000_0000, limiting_r}; // RQ17
            default:         rmux = 32'h0000_0000;
        endcase
    end

    // bus handshake: one wait cycle, then a single ready cycle
    // read data is caught on the edge that ends the wait cycle and held to the next read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r  <= !((read || write) && wait_r);
            rdata_r <= (read && wait_r) ? rmux : rdata_r;
        end
    end

    // settings written by the host
    // limit writes are pulled into range rather than refused
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enlog_r <= 1'b0;
            afmt_r  <= 4'h0;
            sp_r    <= '{default: 16'h0000};
            jog_r   <= 16'h0000;
            decel_r <= 16'h0001;
            loalm_r <= 16'h0000;
            hialm_r <= 16'hFFFF;
            rerr_r  <= 16'hFFFF;
            serr_r  <= 16'hFFFF;
            cont_r  <= MRSC_CONT_MAX;
            peak_r  <= MRSC_PEAK_MAX;
        end else if (wr_now) begin
            case (ofs)
                MRSC_CTRL_OFS: begin
                    enlog_r <= writedata[MRSC_CTRL_ENLOG_BIT];
                    afmt_r  <= writedata[MRSC_CTRL_AFMT_LSB +: 4];
                end
                MRSC_SP1_OFS:   sp_r[0] <= wd16; // RQ19
                MRSC_SP2_OFS:   sp_r[1] <= wd16;
                MRSC_SP3_OFS:   sp_r[2] <= wd16;
                MRSC_SP4_OFS:   sp_r[3] <= wd16;
                MRSC_JOG_OFS:   jog_r   <= wd16;
                MRSC_DECEL_OFS: decel_r <= wd16;
                MRSC_LOALM_OFS: loalm_r <= wd16;
                MRSC_HIALM_OFS: hialm_r <= wd16;
                MRSC_RERR_OFS:  rerr_r  <= wd16;
                MRSC_SERR_OFS:  serr_r  <= wd16;
                MRSC_CONT_OFS:  cont_r  <= cont_wr; // RQ15
                MRSC_PEAK_OFS:  peak_r  <= peak_wr; // RQ16
                default: begin
                end
            endcase
        end
    end

    // outputs
    // each output is a flip-flop with no logic before the pin
    assign readdata       = rdata_r;
    assign waitrequest    = wait_r;
    assign speed_cmd      = spd_r;
    assign follower_mode  = follower_r;
    assign current_clamp  = clamp_r;
    assign drive_enable_n = den_n_r;
    assign alarm_n        = alarm_n_r;
endmodule : mrsc_ctrl

// >>> verif/mrsc_plant.sv
// partner model: motor loop returning pulses and measurements
`timescale 1ns/1ps
module mrsc_plant
    import mrsc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // bench controls
    input  wire logic        fb_on,
    input  wire logic [15:0] current_set,
    // controller outputs
    input  wire logic [15:0] speed_cmd,
    input  wire logic [15:0] current_clamp,
    // loop feedback
    output logic             fb_pulse,
    output mrsc_meas_t       meas
);
    // pulse train; a lost sensor leaves the line quiet
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fb_pulse <= 1'b0;
        end else begin
            fb_pulse <= fb_on & ~fb_pulse;
        end
    end
    // current follows demand but never passes the clamp
    wire [15:0] cur_lim = (current_set > current_clamp) ? current_clamp : current_set;
    assign meas = '{speed: speed_cmd, ramped_err: 16'h0005, scaled_err: 16'h0007,
                    current: cur_lim};
endmodule : mrsc_plant

// >>> verif/mrsc_ctrl_chk.sv
// checker: port-level properties of the run/stop controller
`timescale 1ns/1ps
module mrsc_ctrl_chk
    import mrsc_pkg::*;
(
    // clock and reset
    input wire logic           clock,
    input wire logic           rst_n,
    // bus
    input wire logic           read,
    input wire logic           write,
    input wire logic [31:0]    readdata,
    input wire logic           waitrequest,
    // contacts and drive side
    input wire mrsc_contacts_t contacts,
    input wire logic [15:0]    speed_cmd,
    input wire logic           follower_mode,
    input wire logic [15:0]    current_clamp,
    input wire logic           drive_enable_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // bus handshake
    property p_bus_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
    property p_bus_one; !waitrequest |=> waitrequest; endproperty
    property p_rd_hold; !read |=> $stable(readdata); endproperty
    // stops and outputs
    property p_fstop; !contacts.fstop |-> ##[1:2] speed_cmd == 16'h0000; endproperty
    property p_stop_en; !contacts.fstop || !contacts.rstop |-> ##2 drive_enable_n; endproperty
    property p_ramp; !contacts.rstop [*3] |-> speed_cmd <= $past(speed_cmd); endproperty
    property p_follow; follower_mode == $past(contacts.follower); endproperty
    property p_peak; current_clamp < MRSC_PEAK_MAX; endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus not answered");
    a_bus_one: assert property (p_bus_one) else $error("answer too long");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_fstop: assert property (p_fstop) else $error("fast stop not zero");
    a_stop_en: assert property (p_stop_en) else $error("enable during stop");
    a_ramp: assert property (p_ramp) else $error("speed rose in ramp");
    a_follow: assert property (p_follow) else $error("scaling not follower");
    a_peak: assert property (p_peak) else $error("clamp at peak");
    // main scenarios reached
    c_run: cover property (!drive_enable_n);
    c_ramp: cover property (!contacts.rstop ##1 speed_cmd != 16'h0000);
    c_clamp: cover property (current_clamp == 16'h0028);
endmodule : mrsc_ctrl_chk
bind mrsc_ctrl mrsc_ctrl_chk u_mrsc_ctrl_chk (.clock(clock), .rst_n(rst_n), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .contacts(contacts),
    .speed_cmd(speed_cmd), .follower_mode(follower_mode), .current_clamp(current_clamp),
    .drive_enable_n(drive_enable_n));

// >>> verif/mrsc_ctrl_tb.sv
// testbench: run/stop sequencing, setpoints, limits and host access
`timescale 1ns/1ps
module mrsc_ctrl_tb
    import mrsc_pkg::*;
;
    localparam int TK = 4; // cycles per shortened tick
    logic           clock, rst_n, read, write, waitrequest, fb_pulse, fb_on;
    logic           follower_mode, drive_enable_n, alarm_n;
    logic [5:0]     address, a;
    logic [31:0]    writedata, readdata;
    logic [15:0]    cur_set, speed_cmd, current_clamp, jog_spd;
    logic [15:0]    sp [4];
    logic [3:0]     f;
    logic [31:0]    q_exp [$];
    mrsc_contacts_t ct;
    mrsc_meas_t     meas;
    int             err_count, n_compared, cnt, i;
    mrsc_ctrl #(.TICK_CYC(TK), .WINDOW_MS(20), .ALLOW_MS(3), .FBLOSS_MS(5)) u_mrsc_ctrl (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .contacts(ct), .meas(meas), .fb_pulse(fb_pulse), .speed_cmd(speed_cmd),
        .follower_mode(follower_mode), .current_clamp(current_clamp),
        .drive_enable_n(drive_enable_n), .alarm_n(alarm_n));
    mrsc_plant u_mrsc_plant (.clock(clock), .rst_n(rst_n), .fb_on(fb_on),
        .current_set(cur_set), .speed_cmd(speed_cmd), .current_clamp(current_clamp),
        .fb_pulse(fb_pulse), .meas(meas));
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // one access, held until waitrequest is sampled low
    task automatic bus(input logic [5:0] ad, input logic wr, input logic [31:0] d);
        address <= ad;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic rd(input logic [5:0] ad, input logic [31:0] e);
        q_exp.push_back(e);
        bus(ad, 1'b0, 32'h0000_0000);
    endtask : rd
    task automatic run_tap();
        ct.run <= 1'b1;
        cyc(1);
        ct.run <= 1'b0;
        cyc(4);
    endtask : run_tap
    task automatic fstop_tap();
        ct.fstop <= 1'b0;
        cyc(1);
        ct.fstop <= 1'b1;
        cyc(3);
    endtask : fstop_tap
    task automatic summarize();
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // each completed read is compared with the oldest note
    always @(posedge clock) begin
        if (read === 1'b1 && waitrequest === 1'b0) chk(readdata, q_exp.pop_front());
    end
    // hang guard
    initial begin
        cyc(20000);
        err_count++;
        summarize();
    end
    // main sequence
    initial begin
        void'($urandom(97));
        rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 6'h00; writedata = 32'h0;
        ct = '0; ct.rstop = 1'b1; ct.fstop = 1'b1; fb_on = 1'b1; cur_set = 16'h0000;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        chk(32'(current_clamp), 32'h0000_0095);
        chk(32'(drive_enable_n), 32'h1);
        rd(MRSC_DECEL_OFS, 32'h0000_0001);
        // limit settings clamp to their ranges
        for (i = 0; i < 4; i++) begin
            a = (i < 2) ? MRSC_CONT_OFS : MRSC_PEAK_OFS;
            bus(a, 1'b1, (i % 2) ? 32'h0000_00FF : 32'h0000_0010);
            rd(a, (i % 2) ? ((i < 2) ? 32'h64 : 32'h96) : 32'h28);
        end
        for (i = 0; i < 4; i++) begin
            sp[i] = 16'($urandom_range(1, 16'hFFFE));
            bus(MRSC_SP1_OFS + 6'(4 * i), 1'b1, 32'(sp[i]));
        end
        jog_spd = 16'($urandom_range(1, 16'hFFFE));
        bus(MRSC_JOG_OFS, 1'b1, 32'(jog_spd));
        // every scaling and select pair, run latched by a pulse
        for (i = 0; i < 4; i++) begin
            ct.follower <= i[1];
            ct.sp_sel <= i[0];
            cyc(1);
            run_tap();
            chk(32'(speed_cmd), 32'(sp[i]));
            chk(32'(follower_mode), 32'(i[1]));
            chk(32'(drive_enable_n), 32'h0);
            fstop_tap();
            chk(32'(speed_cmd), 32'h0);
        end
        // run refused while ramped stop is open
        ct.rstop <= 1'b0;
        run_tap();
        ct.rstop <= 1'b1;
        cyc(4);
        chk(32'(speed_cmd), 32'h0);
        // jog held, released, then ignored with run closed
        ct.jog <= 1'b1;
        cyc(4);
        chk(32'(speed_cmd), 32'(jog_spd));
        ct.jog <= 1'b0;
        cyc(3);
        chk(32'(speed_cmd), 32'h0);
        ct.jog <= 1'b1;
        run_tap();
        chk(32'(speed_cmd), 32'(sp[3]));
        ct.jog <= 1'b0;
        fstop_tap();
        // ramped stop: 0x0400 at 0x0040 per tick takes 16 ticks
        bus(MRSC_SP4_OFS, 1'b1, 32'h0000_0400);
        bus(MRSC_DECEL_OFS, 1'b1, 32'h0000_0040);
        run_tap();
        ct.rstop <= 1'b0;
        cyc(4);
        ct.rstop <= 1'b1;
        for (cnt = 0; cnt < 200 && speed_cmd !== 16'h0000; cnt++) @(posedge clock);
        chk(32'(cnt >= 12 * TK && cnt <= 18 * TK), 32'h1);
        // lost feedback while running
        run_tap();
        fb_on <= 1'b0;
        cyc(8 * TK);
        chk(32'(speed_cmd), 32'h0000_FFFF);
        fb_on <= 1'b1;
        fstop_tap();
        // host run with a zero setpoint under both enable logics
        bus(MRSC_SP4_OFS, 1'b1, 32'h0000_0000);
        bus(MRSC_CTRL_OFS, 1'b1, 32'h0000_0001);
        cyc(3);
        chk(32'(drive_enable_n), 32'h1);
        bus(MRSC_CTRL_OFS, 1'b1, 32'h0000_0009);
        cyc(3);
        chk(32'(drive_enable_n), 32'h0);
        bus(MRSC_CTRL_OFS, 1'b1, 32'h0000_0004);
        cyc(3);
        chk(32'(drive_enable_n), 32'h1);
        // over-limit budget against a 4.0 A continuous limit
        bus(MRSC_CONT_OFS, 1'b1, 32'h0000_0028);
        cur_set <= 16'h0050;
        rd(MRSC_CURMON_OFS, 32'h0000_0050);
        for (cnt = 0; cnt < 40 && current_clamp !== 16'h0028; cnt++) @(posedge clock);
        chk(32'(current_clamp), 32'h0000_0028);
        rd(MRSC_LIMMON_OFS, 32'h0000_0001);
        for (cnt = 0; cnt < 120 && current_clamp !== 16'h0095; cnt++) @(posedge clock);
        chk(32'(current_clamp), 32'h0000_0095);
        rd(MRSC_LIMMON_OFS, 32'h0000_0000);
        cur_set <= 16'h0000;
        // alarm formats with every threshold tripped except speed above high
        bus(MRSC_LOALM_OFS, 1'b1, 32'h0000_FFFF);
        bus(MRSC_HIALM_OFS, 1'b1, 32'h0000_0000);
        bus(MRSC_RERR_OFS, 1'b1, 32'h0000_0000);
        bus(MRSC_SERR_OFS, 1'b1, 32'h0000_0000);
        for (i = 0; i < 5; i++) begin
            f = (i == 0) ? 4'h0 : 4'(1 << (i - 1));
            bus(MRSC_CTRL_OFS, 1'b1, 32'({f, 4'h0}));
            cyc(3);
            chk(32'(alarm_n), 32'((f & 4'b1101) == 4'h0));
        end
        cyc(2);
        summarize();
    end
endmodule : mrsc_ctrl_tb
